// *** rtl/regulator_enable_control_regs.sv ***
// Control register bank for buck and linear regulator channels
`timescale 1ns/10ps
`include "regulator_enable_control_params.svh"

// Operation
// - Source code 00 sequencer, else inputs 1..3
// - Enable input: active edge on, passive off
// - Buck voltage input: active B, passive A
// - Linear voltage input: active B, passive A
// - Buck bit 0 switches converter
// - Linear bit 0 switches regulator
// - Default-supply bit: bit 3 buck four and three (buck one has none), 7 linear
// - Linear bit 3 clear: pull-down when off
// - Shared select register chooses A or B
// - Input type bit sets active level
module regulator_enable_control_regs #(
  parameter int CHANNELS = 5,
  parameter int INPUTS   = 3
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire logic [8:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_addr_hit,
  input  wire logic [INPUTS-1:0]   general_input,
  input  wire logic [INPUTS-1:0]   input_active_high,
  input  wire logic [CHANNELS-1:0] sequencer_on,
  input  wire logic [CHANNELS-1:0] sequencer_setting_b,
  output logic      [CHANNELS-1:0] channel_on,
  output logic      [CHANNELS-1:0] setting_b,
  output logic      [CHANNELS-1:0] default_supply,
  output logic      [1:0]          pulldown_on
);
  logic [7:0]          ctrl_r [CHANNELS];
  logic [7:0]          select_r;
  logic [INPUTS-1:0]   rise_active;
  logic [INPUTS-1:0]   fall_passive;
  logic [CHANNELS-1:0] on_r;
  logic [CHANNELS-1:0] sel_b_r;
  logic [CHANNELS-1:0] on_nxt;

  function automatic logic is_linear(input int ch);
    return ch >= int'(regulator_enable_control_pkg::CH_LINEAR_ONE);
  endfunction : is_linear

  function automatic logic [8:0] chan_offset(input int ch);
    case (ch)
      0:       return `OFS_BUCK_ONE_LOW;
      1:       return `OFS_BUCK_FOUR;
      2:       return `OFS_BUCK_THREE;
      3:       return `OFS_LINEAR_ONE;
      default: return `OFS_LINEAR_TWO;
    endcase
  endfunction : chan_offset

  function automatic logic [7:0] chan_wmask(input int ch);
    if (ch == 0) begin
      return `BUCK_ONE_LOW_WMASK;
    end
    return is_linear(ch) ? `LINEAR_WMASK : `SWITCHER_WMASK;
  endfunction : chan_wmask

  // Event on the chosen input; sequencer code yields none
  function automatic logic src_event(input logic [1:0] src, input logic [INPUTS-1:0] ev);
    case (regulator_enable_control_pkg::source_type'(src))
      regulator_enable_control_pkg::SRC_SEQUENCER:   return 1'b0;
      regulator_enable_control_pkg::SRC_INPUT_ONE:   return ev[0];
      regulator_enable_control_pkg::SRC_INPUT_TWO:   return ev[1];
      regulator_enable_control_pkg::SRC_INPUT_THREE: return ev[2];
      default:                                        return 1'b0;
    endcase
  endfunction : src_event

  input_edge_detect #(
    .WIDTH (INPUTS)
  ) u_edges (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_in       (general_input),
    .active_high  (input_active_high),
    .rise_active  (rise_active),
    .fall_passive (fall_passive)
  );

  // Reserved channel bits are not writable and read as zero; select bits 7:5 are stored and read back
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        ctrl_r[i] <= `CONTROL_RESET;
      end
    end else if (reg_write) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (reg_addr == chan_offset(i)) begin
          ctrl_r[i] <= reg_wdata & chan_wmask(i);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      select_r <= `SELECT_RESET;
    end else if (reg_write && reg_addr == `OFS_VOLTAGE_SELECT) begin
      select_r <= reg_wdata;
    end
  end

  // Input edges drive the on state; a register write of bit 0 also sets it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_r <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (src_event(ctrl_r[i][`FLD_EN_SRC_HI:`FLD_EN_SRC_LO], rise_active)) begin
          on_r[i] <= 1'b1;
        end else if (src_event(ctrl_r[i][`FLD_EN_SRC_HI:`FLD_EN_SRC_LO], fall_passive)) begin
          on_r[i] <= 1'b0;
        end else if (reg_write && reg_addr == chan_offset(i)) begin
          on_r[i] <= reg_wdata[`FLD_ON];
        end
      end
    end
  end

  // Voltage selection: input edges or shared select register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_b_r <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (src_event(ctrl_r[i][`FLD_VOLT_SRC_HI:`FLD_VOLT_SRC_LO], rise_active)) begin
          sel_b_r[i] <= 1'b1;
        end else if (src_event(ctrl_r[i][`FLD_VOLT_SRC_HI:`FLD_VOLT_SRC_LO], fall_passive)) begin
          sel_b_r[i] <= 1'b0;
        end else if (reg_write && reg_addr == `OFS_VOLTAGE_SELECT) begin
          sel_b_r[i] <= reg_wdata[i];
        end
      end
    end
  end

  // Sequencer request is ORed into the on state when its source code is zero
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      on_nxt[i] = (ctrl_r[i][`FLD_EN_SRC_HI:`FLD_EN_SRC_LO] == 2'h0)
                  ? (on_r[i] | sequencer_on[i]) : on_r[i];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      channel_on     <= '0;
      setting_b      <= '0;
      default_supply <= '0;
      pulldown_on    <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_on[i] <= on_nxt[i];
        setting_b[i]  <= (ctrl_r[i][`FLD_VOLT_SRC_HI:`FLD_VOLT_SRC_LO] == 2'h0)
                         ? (sel_b_r[i] | sequencer_setting_b[i]) : sel_b_r[i];
        default_supply[i] <= is_linear(i) ? ctrl_r[i][`FLD_DEFAULT_SUPPLY_LIN]
                                          : ctrl_r[i][`FLD_DEFAULT_SUPPLY_SW];
      end
      for (int j = 0; j < 2; j++) begin
        // Same next state as channel_on, so pull-down never overlaps an on output
        pulldown_on[j] <= ~on_nxt[3+j] & ~ctrl_r[3+j][`FLD_PULLDOWN_OFF];
      end
    end
  end

  // Channel reads show stored fields with live on state in bit 0
  always_comb begin
    reg_rdata    = 8'h00;
    reg_addr_hit = 1'b0;
    if (reg_addr == `OFS_VOLTAGE_SELECT) begin
      reg_rdata    = {{(8-CHANNELS){1'b0}}, sel_b_r} | (select_r & 8'hE0);
      reg_addr_hit = 1'b1;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (reg_addr == chan_offset(i)) begin
        reg_rdata    = (ctrl_r[i] & 8'hFE) | {7'h00, on_r[i]};
        reg_addr_hit = 1'b1;
      end
    end
  end
endmodule : regulator_enable_control_regs

// *** rtl/regulator_enable_control_params.svh ***
// Offsets, field positions and reset values for the regulator control registers
`ifndef REGULATOR_ENABLE_CONTROL_PARAMS_SVH
`define REGULATOR_ENABLE_CONTROL_PARAMS_SVH

`define OFS_BUCK_ONE_LOW    9'h021
`define OFS_BUCK_FOUR       9'h022
`define OFS_BUCK_THREE      9'h024
`define OFS_LINEAR_ONE      9'h026
`define OFS_LINEAR_TWO      9'h027
`define OFS_VOLTAGE_SELECT  9'h032

`define FLD_ON              0
`define FLD_EN_SRC_LO       1
`define FLD_EN_SRC_HI       2
`define FLD_DEFAULT_SUPPLY_SW 3
`define FLD_PULLDOWN_OFF    3
`define FLD_VOLT_SRC_LO     5
`define FLD_VOLT_SRC_HI     6
`define FLD_DEFAULT_SUPPLY_LIN 7

`define SWITCHER_WMASK      8'h6F
`define LINEAR_WMASK        8'hEF
`define BUCK_ONE_LOW_WMASK  8'h07
`define CONTROL_RESET       8'h00
`define SELECT_RESET        8'h00

`endif

// *** rtl/regulator_enable_control_pkg.sv ***
// Types shared by the regulator control register bank
package regulator_enable_control_pkg;
  typedef enum logic [1:0] {
    SRC_SEQUENCER = 2'h0,
    SRC_INPUT_ONE = 2'h1,
    SRC_INPUT_TWO = 2'h2,
    SRC_INPUT_THREE = 2'h3
  } source_type;
  // Channel order in all per-channel vectors
  typedef enum logic [2:0] {
    CH_BUCK_ONE = 3'h0,
    CH_BUCK_FOUR = 3'h1,
    CH_BUCK_THREE = 3'h2,
    CH_LINEAR_ONE = 3'h3,
    CH_LINEAR_TWO = 3'h4
  } channel_type;
endpackage : regulator_enable_control_pkg

// *** rtl/input_edge_detect.sv ***
// Synchronises the general inputs, applies polarity, flags edges
`timescale 1ns/10ps
module input_edge_detect #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] active_high,
  output logic      [WIDTH-1:0] rise_active,
  output logic      [WIDTH-1:0] fall_passive
);
  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;
  logic [1:0]       prime_cnt_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Type bit sets which level is active
  assign level_nxt = ~(sync2_r ^ active_high);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      level_r     <= '0;
      prime_cnt_r <= 2'h0;
    end else begin
      level_r <= level_nxt;
      // Count until both sync stages and the level flop hold real samples
      if (prime_cnt_r != 2'h3) begin
        prime_cnt_r <= prime_cnt_r + 2'h1;
      end
    end
  end

  // No edges until the first settled sample is held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rise_active  <= '0;
      fall_passive <= '0;
    end else begin
      rise_active  <= (prime_cnt_r == 2'h3) ? (level_nxt & ~level_r) : '0;
      fall_passive <= (prime_cnt_r == 2'h3) ? (~level_nxt & level_r) : '0;
    end
  end
endmodule : input_edge_detect

// *** test/control_host.sv ***
// Host and input-pin model for the regulator control bank
`timescale 1ns/10ps
module control_host (
  input  wire logic       ref_clk,
  output logic            reg_write,
  output logic      [8:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic      [2:0] general_input
);
  initial {reg_write, reg_addr, reg_wdata, general_input} = '0;
  // Returns once the outputs have taken the byte
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d & (a == 9'h032 ? 8'hFF : a < 9'h026 ? 8'h6F : 8'hEF);
    @(posedge ref_clk);
    reg_write <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [8:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    #1;
  endtask : rd
  // Waits out the synchroniser, edge flag and output flop
  task automatic pin(input logic [2:0] v);
    @(posedge ref_clk);
    general_input <= v;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : pin
endmodule : control_host

// *** test/regulator_enable_control_props.sv ***
// Concurrent checks on the regulator control bank ports
`timescale 1ns/10ps
module regulator_enable_control_props #(
  parameter int CHANNELS = 5,
  parameter int INPUTS   = 3
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                reg_write,
  input wire logic [8:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic                reg_addr_hit,
  input wire logic [CHANNELS-1:0] sequencer_on,
  input wire logic [CHANNELS-1:0] channel_on,
  input wire logic [CHANNELS-1:0] default_supply,
  input wire logic [1:0]          pulldown_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence wr_s(a);
    reg_write && reg_addr == a && reg_wdata[2:1] == 2'h0 && sequencer_on == '0
      ##1 (!reg_write && sequencer_on == '0) [*2];
  endsequence
  reset_clear_a: assert property ($fell(rst) |-> channel_on == '0)
    else $error("channel on after reset");
  buck_on_a: assert property (wr_s(9'h022) |=> channel_on[1] == $past(reg_wdata[0], 3))
    else $error("buck switch wrong");
  lin_on_a: assert property (wr_s(9'h027) |=> channel_on[4] == $past(reg_wdata[0], 3))
    else $error("linear switch wrong");
  conf_sw_a: assert property (wr_s(9'h022) |=> default_supply[1] == $past(reg_wdata[3], 3))
    else $error("default supply wrong");
  pd_follow_a: assert property (wr_s(9'h027) |=>
    pulldown_on[1] == !($past(reg_wdata[0], 3) || $past(reg_wdata[3], 3))) else $error("pd wrong");
  pd_excl_a: assert property (pulldown_on[0] |-> !channel_on[3])
    else $error("pull-down while on");
  unmapped_a: assert property (reg_addr == 9'h023 |-> !reg_addr_hit && reg_rdata == 8'h00)
    else $error("unmapped address answered");
  readback_a: assert property (reg_write && reg_addr == 9'h026 ##1 reg_addr == 9'h026 |->
    reg_rdata[7:1] == ($past(reg_wdata[7:1]) & 7'h77)) else $error("read-back wrong");
  cover property (wr_s(9'h027));
  cover property ($rose(channel_on[3]));
  cover property ($fell(channel_on[3]));
endmodule : regulator_enable_control_props

bind regulator_enable_control_regs regulator_enable_control_props #(
  .CHANNELS(CHANNELS), .INPUTS(INPUTS)
) props_u (.ref_clk, .rst, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .reg_addr_hit,
  .sequencer_on, .channel_on, .default_supply, .pulldown_on);

// *** test/regulator_enable_control_regs_tb.sv ***
// Self-checking bench for the regulator control bank
`timescale 1ns/10ps
module regulator_enable_control_regs_tb;
  logic       ref_clk = 1'b0, rst = 1'b1, reg_write, reg_addr_hit;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [2:0] general_input, input_active_high = 3'h7;
  logic [4:0] sequencer_on = 5'h00, channel_on, setting_b, default_supply;
  logic [1:0] pulldown_on;
  logic [4:0] sequencer_setting_b = 5'h00;
  int         miscompares = 0, checks_done = 0;
  initial forever #5 ref_clk = ~ref_clk;
  control_host host_u (.ref_clk, .reg_write, .reg_addr, .reg_wdata, .general_input);
  regulator_enable_control_regs dut_u (.ref_clk, .rst, .reg_write, .reg_read(1'b0), .reg_addr,
    .reg_wdata, .reg_rdata, .reg_addr_hit, .general_input, .input_active_high, .sequencer_on,
    .sequencer_setting_b, .channel_on, .setting_b, .default_supply, .pulldown_on);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    input_active_high <= 3'h3;
    repeat (8) @(posedge ref_clk);
    host_u.rd(9'h023);
    chk({reg_addr_hit, reg_rdata}, 9'h000);
    chk(channel_on, 5'h00);
    host_u.wr(9'h022, 8'hF9);
    chk({channel_on[1], default_supply[1]}, 2'h3);
    host_u.rd(9'h022);
    chk(reg_rdata, 8'h69);
    for (int i = 0; i < 3; i++) begin
      host_u.wr(9'h026, 8'(2 * i + 2));
      host_u.pin(~input_active_high ^ 3'(1 << i));
      chk({channel_on[3], pulldown_on[0]}, 2'h2);
      host_u.pin(~input_active_high);
      chk({channel_on[3], pulldown_on[0]}, 2'h1);
    end
    host_u.wr(9'h024, 8'h40);
    host_u.wr(9'h027, 8'h60);
    host_u.pin(input_active_high);
    chk(setting_b, 5'h16);
    host_u.pin(~input_active_high);
    chk(setting_b, 5'h00);
    host_u.wr(9'h032, 8'h02);
    chk(setting_b, 5'h02);
    host_u.wr(9'h027, 8'h89);
    chk({channel_on[4], default_supply[4], pulldown_on[1]}, 3'h6);
    host_u.wr(9'h027, 8'h08);
    chk({channel_on[4], pulldown_on[1]}, 2'h0);
    host_u.wr(9'h027, 8'h00);
    chk(pulldown_on[1], 1'b1);
    @(posedge ref_clk);
    sequencer_on <= 5'h10;
    sequencer_setting_b <= 5'h01;
    repeat (3) @(posedge ref_clk);
    host_u.rd(9'h027);
    chk(channel_on[4], 1'b1);
    chk(setting_b, 5'h03);
    close_out();
  end
endmodule : regulator_enable_control_regs_tb
